// *** core/xio_port.sv ***
// Purpose: Main 8-bit output port plus 64 extended I/O points
// Assumes: Commands are one-cycle strobes synchronous to clk_sys_in
// Notes: Stored image is restored by restore_in after power-up
//
// Operation
// - Sixty-four extended points exist, direction chosen per group of eight.
// - Extended points 17 to 80 form blocks 2 to 9, block k starting at 17+8(k-2).
// - An eight-bit direction mask holds one bit per block, one meaning output.
// - Mask bit zero steers block 2 and the top bit steers block 9.
// - A save stores the mask and the output states in nonvolatile memory.
// - With nothing ever stored the mask is zero, all blocks inputs.
// - Any point 1 to 8 or 17 to 80 set as output can be set or cleared alone.
// - A conditional write sets the point for a nonzero value, clears it for zero.
// - The group write takes five values, the first driving main outputs 1 to 8.
// - Bit weight one of the main value maps to output 1, a one drives it on.
// - Four 16-bit values cover block pairs 2-3, 4-5, 6-7 and 8-9 in order.
// - Group-write bits landing on input points have no effect.
// - A given group value overwrites the output points of its group; omitted groups stay.
// - A block read takes selector 0 or 2 to 9 and returns that block's levels.
// - A point read returns the level of point 1-8 or 17-80, 17 being block 2 bit 0.
`timescale 1ns/1ps
`default_nettype none
module xio_port #(
  parameter int unsigned EXT_POINTS = 64
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic dir_write_in,
  input wire logic [7:0] io_direction_mask_in,
  input wire xio_pkg::xio_bit_cmd_t bit_cmd_in,
  input wire xio_pkg::xio_group_cmd_t output_group_write_in,
  input wire logic save_to_nonvolatile_in,
  input wire logic restore_in,
  input wire logic block_level_read_in,
  input wire logic [3:0] block_sel_in,
  input wire logic point_read_in,
  input wire logic [6:0] point_sel_in,
  input wire logic [63:0] ext_pin_in,
  output logic [7:0] main_pin_out,
  output logic [63:0] ext_pin_out,
  output logic [63:0] ext_pin_oe_out,
  output logic [7:0] io_direction_mask_out,
  output logic [7:0] block_value_out,
  output logic block_valid_out,
  output logic block_error_out,
  output logic point_value_out,
  output logic point_valid_out,
  output logic point_error_out,
  output logic busy_out
);

  // ----------------------------------------------------------------
  // Types and functions
  // ----------------------------------------------------------------
  typedef enum {
    XIO_IDLE,
    XIO_LOAD_WAIT,
    XIO_LOAD
  } xio_state_t;

  typedef struct packed {
    xio_state_t st;
    logic [7:0] mask;
    logic [7:0] main_out;
    logic [63:0] ext_out;
    logic [7:0] main_pin;
    logic [63:0] ext_pin;
    logic [63:0] ext_oe;
    logic [7:0] blk_val;
    logic blk_vld;
    logic blk_err;
    logic pt_val;
    logic pt_vld;
    logic pt_err;
    logic busy;
  } xio_regs_t;

  // Expand block mask to per-point enables
  function automatic logic [63:0] xio_expand(input logic [7:0] m);
    logic [63:0] r;
    r = 64'h0;
    for (int b = 0; b < 8; b++) begin
      r[b*8 +: 8] = {8{m[b]}};
    end
    return r;
  endfunction

  // Point number to extended index
  function automatic logic [5:0] xio_ext_index(input logic [6:0] p);
    logic [6:0] d;
    d = p - xio_pkg::EXT_FIRST_POINT;
    return d[5:0];
  endfunction

  function automatic logic xio_is_main(input logic [6:0] p);
    return (p >= xio_pkg::MAIN_FIRST_POINT) && (p <= xio_pkg::MAIN_LAST_POINT);
  endfunction

  function automatic logic xio_is_ext(input logic [6:0] p);
    return (p >= xio_pkg::EXT_FIRST_POINT) && (p <= xio_pkg::EXT_LAST_POINT);
  endfunction

  // Block of an extended point, 0 for block 2
  function automatic logic [2:0] xio_ext_block(input logic [6:0] p);
    logic [5:0] i;
    i = xio_ext_index(p);
    return i[5:3];
  endfunction

  // Readback view: latch on output blocks, pins on input blocks
  function automatic logic [63:0] xio_read_view(input logic [7:0] m, input logic [63:0] lat,
      input logic [63:0] pin);
    logic [63:0] e;
    e = xio_expand(m);
    return (lat & e) | (pin & ~e);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  xio_regs_t r;
  xio_regs_t next_r;
  xio_pkg::xio_image_t image_wr;
  logic [87:0] image_rd;
  xio_pkg::xio_image_t image;

  assign image = xio_pkg::xio_image_t'(image_rd);

  assign image_wr = '{marker: xio_pkg::STORE_MAGIC, mask: r.mask,
                      main_out: r.main_out, ext_out: r.ext_out};

  xio_nv_store #(
    .WIDTH(88)
  ) u_store (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(save_to_nonvolatile_in && (r.st == XIO_IDLE)),
    .wr_data_in(image_wr),
    .rd_data_out(image_rd)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [63:0] oe;
    logic [63:0] gmask;
    logic [63:0] gval;
    logic [6:0] p;
    logic bitval;
    logic [3:0] bs;
    logic [6:0] bstart;
    logic [63:0] view;
    next_r = r;
    oe = 64'h0;
    gmask = 64'h0;
    gval = 64'h0;
    p = bit_cmd_in.point;
    bitval = 1'b0;
    bs = 4'h0;
    bstart = 7'h0;
    view = xio_read_view(r.mask, r.ext_out, ext_pin_in);
    next_r.blk_vld = 1'b0;
    next_r.pt_vld = 1'b0;
    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    case (r.st)
      XIO_IDLE: begin
        if (dir_write_in) begin
          next_r.mask = io_direction_mask_in;
        end
        if (bit_cmd_in.set_output_bit || bit_cmd_in.clear_output_bit ||
            bit_cmd_in.conditional_output_bit) begin
          bitval = bit_cmd_in.set_output_bit ||
                   (bit_cmd_in.conditional_output_bit && bit_cmd_in.cond_nonzero);
          if (xio_is_main(p)) begin
            next_r.main_out[3'(p - xio_pkg::MAIN_FIRST_POINT)] = bitval;
          end else if (xio_is_ext(p) && r.mask[xio_ext_block(p)]) begin
            next_r.ext_out[xio_ext_index(p)] = bitval;
          end
        end
        if (output_group_write_in.valid) begin
          if (output_group_write_in.main_given) begin
            next_r.main_out = output_group_write_in.main_value;
          end
          // four 16-bit groups in block-pair order
          for (int g = 0; g < 4; g++) begin
            if (output_group_write_in.group_given[g]) begin
              gmask[g*16 +: 16] = 16'hffff;
            end
          end
          gval = output_group_write_in.group_value;
          gmask = gmask & xio_expand(r.mask);
          next_r.ext_out = (next_r.ext_out & ~gmask) | (gval & gmask);
        end
        if (restore_in) begin
          next_r.st = XIO_LOAD_WAIT;
          next_r.busy = 1'b1;
        end
      end
      XIO_LOAD_WAIT: begin
        next_r.st = XIO_LOAD;
      end
      XIO_LOAD: begin
        if (image.marker == xio_pkg::STORE_MAGIC) begin
          next_r.mask = image.mask;
          next_r.main_out = image.main_out;
          next_r.ext_out = image.ext_out;
        end
        next_r.st = XIO_IDLE;
        next_r.busy = 1'b0;
      end
      default: begin
        next_r.st = XIO_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    // per-block direction
    // mask bit 0 is block 2
    oe = xio_expand(next_r.mask);
    next_r.ext_oe = oe;
    next_r.ext_pin = next_r.ext_out & oe;
    next_r.main_pin = next_r.main_out;

    // ----------------------------------------------------------------
    // Reads
    // ----------------------------------------------------------------
    // block read
    if (block_level_read_in) begin
      next_r.blk_vld = 1'b1;
      next_r.blk_err = 1'b0;
      bs = block_sel_in;
      if (bs == xio_pkg::MAIN_BLOCK_SEL) begin
        next_r.blk_val = r.main_out;
      end else if (bs >= xio_pkg::EXT_FIRST_BLOCK && bs <= xio_pkg::EXT_LAST_BLOCK) begin
        bstart = 7'((bs - xio_pkg::EXT_FIRST_BLOCK) * 8);
        next_r.blk_val = view[bstart[5:0] +: 8];
      end else begin
        next_r.blk_val = 8'h00;
        next_r.blk_err = 1'b1;
      end
    end

    if (point_read_in) begin
      next_r.pt_vld = 1'b1;
      next_r.pt_err = 1'b0;
      if (xio_is_main(point_sel_in)) begin
        next_r.pt_val = r.main_out[3'(point_sel_in - xio_pkg::MAIN_FIRST_POINT)];
      end else if (xio_is_ext(point_sel_in)) begin
        next_r.pt_val = view[xio_ext_index(point_sel_in)];
      end else begin
        next_r.pt_val = 1'b0;
        next_r.pt_err = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{st: XIO_IDLE, mask: xio_pkg::DIR_MASK_RESET,
             main_out: xio_pkg::MAIN_OUT_RESET, ext_out: xio_pkg::EXT_OUT_RESET,
             main_pin: xio_pkg::MAIN_OUT_RESET, ext_pin: xio_pkg::EXT_OUT_RESET,
             ext_oe: 64'h0, blk_val: 8'h00, blk_vld: 1'b0, blk_err: 1'b0,
             pt_val: 1'b0, pt_vld: 1'b0, pt_err: 1'b0, busy: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign main_pin_out = r.main_pin;
  assign ext_pin_out = r.ext_pin;
  assign ext_pin_oe_out = r.ext_oe;
  assign io_direction_mask_out = r.mask;
  assign block_value_out = r.blk_val;
  assign block_valid_out = r.blk_vld;
  assign block_error_out = r.blk_err;
  assign point_value_out = r.pt_val;
  assign point_valid_out = r.pt_vld;
  assign point_error_out = r.pt_err;
  assign busy_out = r.busy;

endmodule
`default_nettype wire

// *** core/xio_pkg.sv ***
// Purpose: Shared constants and carriers for the extended I/O port
// Assumes: Single clock domain, command strobes one cycle wide
// Notes: Point numbers are the user-visible 1..8 and 17..80
package xio_pkg;

  localparam int unsigned MAIN_WIDTH = 8;
  localparam int unsigned EXT_BLOCKS = 8;
  localparam int unsigned BLOCK_WIDTH = 8;
  localparam int unsigned EXT_WIDTH = 64;
  localparam int unsigned GROUP_WIDTH = 16;
  localparam int unsigned GROUP_COUNT = 4;
  localparam logic [6:0] MAIN_FIRST_POINT = 7'h01;
  localparam logic [6:0] MAIN_LAST_POINT = 7'h08;
  localparam logic [6:0] EXT_FIRST_POINT = 7'h11;
  localparam logic [6:0] EXT_LAST_POINT = 7'h50;
  localparam logic [3:0] MAIN_BLOCK_SEL = 4'h0;
  localparam logic [3:0] EXT_FIRST_BLOCK = 4'h2;
  localparam logic [3:0] EXT_LAST_BLOCK = 4'h9;
  localparam logic [7:0] DIR_MASK_RESET = 8'h00;
  localparam logic [7:0] MAIN_OUT_RESET = 8'h00;
  localparam logic [63:0] EXT_OUT_RESET = 64'h0;
  localparam logic [7:0] STORE_MAGIC = 8'ha5;

  // Point command
  typedef struct packed {
    logic set_output_bit;
    logic clear_output_bit;
    logic conditional_output_bit;
    logic [6:0] point;
    logic cond_nonzero;
  } xio_bit_cmd_t;

  // Group write command
  typedef struct packed {
    logic valid;
    logic main_given;
    logic [7:0] main_value;
    logic [3:0] group_given;
    logic [63:0] group_value;
  } xio_group_cmd_t;

  // Nonvolatile image: marker, mask, outputs
  typedef struct packed {
    logic [7:0] marker;
    logic [7:0] mask;
    logic [7:0] main_out;
    logic [63:0] ext_out;
  } xio_image_t;

endpackage

// *** core/xio_nv_store.sv ***
// Purpose: Nonvolatile image store for direction and output states
// Assumes: Contents survive the logic reset (no reset on the array)
// Notes: Read data is registered; one image word
`timescale 1ns/1ps
`default_nettype none
module xio_nv_store #(
  parameter int unsigned WIDTH = 88
) (
  input wire logic clk_sys_in,
  input wire logic wr_en_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem [0:0];

  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[0] <= wr_data_in;
    end
    rd_data_out <= mem[0];
  end

endmodule
`default_nettype wire

// *** bench/xio_port_checker.sv ***
// Purpose: Port assertions for the extended I/O port
// Assumes: One clock, async active-low reset
// Notes: Bound to xio_port
`timescale 1ns/1ps
`default_nettype none
module xio_port_checker (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic dir_write_in,
  input wire logic [7:0] io_direction_mask_in,
  input wire xio_pkg::xio_bit_cmd_t bit_cmd_in,
  input wire xio_pkg::xio_group_cmd_t output_group_write_in,
  input wire logic block_level_read_in,
  input wire logic [7:0] main_pin_out,
  input wire logic [63:0] ext_pin_out,
  input wire logic [63:0] ext_pin_oe_out,
  input wire logic [7:0] io_direction_mask_out,
  input wire logic block_valid_out,
  input wire logic busy_out
);
  logic [63:0] oe_exp;
  logic main_bit;
  always_comb begin
    for (int k = 0; k < 8; k++) oe_exp[k*8+:8] = {8{io_direction_mask_out[k]}};
  end
  assign main_bit = !busy_out && !output_group_write_in.valid && bit_cmd_in.point inside {[1:8]};
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_oe_from_mask: assert property (ext_pin_oe_out == oe_exp)
    else $error("oe wrong");
  a_pins_gated: assert property ((ext_pin_out & ~ext_pin_oe_out) == 64'h0)
    else $error("input driven");
  a_mask_load: assert property (dir_write_in && !busy_out |=>
    io_direction_mask_out == $past(io_direction_mask_in)) else $error("mask load");
  a_main_set: assert property (main_bit && bit_cmd_in.set_output_bit |=>
    main_pin_out[$past(bit_cmd_in.point) - 7'h01]) else $error("set bit");
  a_main_clear: assert property (main_bit && bit_cmd_in.clear_output_bit |=>
    !main_pin_out[$past(bit_cmd_in.point) - 7'h01]) else $error("clear bit");
  a_cond_main: assert property (main_bit && bit_cmd_in.conditional_output_bit |=>
    main_pin_out[$past(bit_cmd_in.point) - 7'h01] == $past(bit_cmd_in.cond_nonzero))
    else $error("cond bit");
  a_group_main: assert property (output_group_write_in.valid && !busy_out &&
    output_group_write_in.main_given |=> main_pin_out == $past(output_group_write_in.main_value))
    else $error("main group");
  a_block_answer: assert property (block_level_read_in |=> block_valid_out)
    else $error("no block answer");
  c_restore: cover property ($fell(busy_out));
  c_group: cover property (output_group_write_in.valid && output_group_write_in.group_given != 4'h0);
  c_read: cover property (block_valid_out);
endmodule
bind xio_port xio_port_checker u_chk (.clk_sys_in, .rst_n_in, .dir_write_in,
  .io_direction_mask_in, .bit_cmd_in, .output_group_write_in, .block_level_read_in,
  .main_pin_out, .ext_pin_out, .ext_pin_oe_out, .io_direction_mask_out, .block_valid_out,
  .busy_out);
`default_nettype wire

// *** bench/xio_rack_model.sv ***
// Purpose: External rack on the extended pins
// Assumes: Switch levels come from the bench
// Notes: Output points read back as driven, except blocks 5 and 9, held low while attached
`timescale 1ns/1ps
`default_nettype none
module xio_rack_model (
  input wire logic attached_in,
  input wire logic [63:0] drive_in,
  input wire logic [63:0] oe_in,
  input wire logic [63:0] levels_in,
  output logic [63:0] pin_out
);
  logic [63:0] gnd;
  assign gnd = attached_in ? 64'hff00_0000_ff00_0000 : 64'h0;
  assign pin_out = ((drive_in & oe_in) | (levels_in & ~oe_in)) & ~gnd;
endmodule
`default_nettype wire

// *** bench/test_extended_io_port.sv ***
// Purpose: Self-checking bench for the extended I/O port
// Assumes: Rack model on the extended pins
// Notes: Inputs move 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module test_extended_io_port;
  logic clk_sys_in = 1'h0, rst_n_in = 1'h0, dir_write_in = 1'h0, restore_in = 1'h0, busy_out;
  logic save_to_nonvolatile_in = 1'h0, block_level_read_in = 1'h0, point_read_in = 1'h0;
  logic [7:0] io_direction_mask_in = 8'h00, main_pin_out, io_direction_mask_out, block_value_out;
  logic [3:0] block_sel_in = 4'h0;
  logic rack_on = 1'h0;
  logic [6:0] point_sel_in = 7'h00;
  xio_pkg::xio_bit_cmd_t bit_cmd_in = '0;
  xio_pkg::xio_group_cmd_t output_group_write_in = '0;
  logic [63:0] ext_pin_in, ext_pin_out, ext_pin_oe_out;
  logic block_valid_out, block_error_out, point_value_out, point_valid_out, point_error_out;
  int miscompares = 0, samples_checked = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  xio_port DUT (.clk_sys_in, .rst_n_in, .dir_write_in, .io_direction_mask_in, .bit_cmd_in,
    .output_group_write_in, .save_to_nonvolatile_in, .restore_in, .block_level_read_in,
    .block_sel_in, .point_read_in, .point_sel_in, .ext_pin_in, .main_pin_out, .ext_pin_out,
    .ext_pin_oe_out, .io_direction_mask_out, .block_value_out, .block_valid_out,
    .block_error_out, .point_value_out, .point_valid_out, .point_error_out, .busy_out);
  xio_rack_model rack (.attached_in(rack_on), .drive_in(ext_pin_out), .oe_in(ext_pin_oe_out),
    .levels_in(64'h3c3c_a5a5_0f0f_9696), .pin_out(ext_pin_in));
  task automatic chk(input logic [79:0] s, input logic [79:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic dir(input logic [7:0] m);
    dir_write_in = 1'h1;
    io_direction_mask_in = m;
    @(posedge clk_sys_in) #1;
    dir_write_in = 1'h0;
    @(posedge clk_sys_in) #1;
  endtask
  task automatic pt(input logic [2:0] k, input logic [6:0] p, input logic n);
    bit_cmd_in = {k, p, n};
    @(posedge clk_sys_in) #1;
    bit_cmd_in = '0;
    @(posedge clk_sys_in) #1;
  endtask
  task automatic grp(input logic [8:0] m, input logic [3:0] g, input logic [63:0] v);
    output_group_write_in = {1'h1, m, g, v};
    @(posedge clk_sys_in) #1;
    output_group_write_in = '0;
    @(posedge clk_sys_in) #1;
  endtask
  task automatic nv(input logic r);
    save_to_nonvolatile_in = !r;
    restore_in = r;
    @(posedge clk_sys_in) #1;
    save_to_nonvolatile_in = 1'h0;
    restore_in = 1'h0;
    chk(busy_out, r);
    if (r) @(posedge clk_sys_in) #1;
    chk(busy_out, r);
    if (r) @(posedge clk_sys_in) #1;
    chk(busy_out, 1'h0);
    @(posedge clk_sys_in) #1;
  endtask
  task automatic rd(input logic p, input logic [6:0] s, input logic [7:0] v, input logic e);
    block_level_read_in = !p;
    point_read_in = p;
    block_sel_in = s[3:0];
    point_sel_in = s;
    @(posedge clk_sys_in) #1;
    block_level_read_in = 1'h0;
    point_read_in = 1'h0;
    if (p) chk({point_valid_out, point_error_out, point_value_out}, {1'h1, e, v[0]});
    else chk({block_valid_out, block_error_out, block_value_out}, {1'h1, e, v});
    @(posedge clk_sys_in) #1;
  endtask
  task automatic t_dir();
    chk({io_direction_mask_out, main_pin_out, ext_pin_oe_out}, 80'h0);
    nv(1'h1);
    chk(io_direction_mask_out, 8'h00);
    for (int k = 0; k < 8; k++) begin
      dir(8'h01 << k);
      chk(ext_pin_oe_out, 64'hff << (8 * k));
    end
    $display("direction test done");
  endtask
  task automatic t_write();
    dir(8'h01);
    // rack on only with blocks 5 and 9 inputs
    rack_on = 1'h1;
    pt(3'h4, 7'h11, 1'h0);
    pt(3'h4, 7'h19, 1'h0);
    pt(3'h4, 7'h08, 1'h0);
    pt(3'h1, 7'h01, 1'h1);
    pt(3'h4, 7'h09, 1'h0);
    chk({main_pin_out, ext_pin_out}, {8'h81, 64'h1});
    pt(3'h2, 7'h08, 1'h0);
    pt(3'h1, 7'h01, 1'h0);
    chk(main_pin_out, 8'h00);
    dir(8'h40);
    grp(9'h107, 4'h8, 64'h0007_0000_0000_0000);
    chk({main_pin_out, ext_pin_out}, {8'h07, 64'h0007_0000_0000_0000});
    grp(9'h000, 4'h9, 64'hffff_0000_0000_0000);
    chk({main_pin_out, ext_pin_out}, {8'h07, 64'h00ff_0000_0000_0000});
    dir(8'h41);
    chk(ext_pin_out, 64'h00ff_0000_0000_0001);
    grp(9'h105, 4'h8, 64'h0);
    chk({main_pin_out, ext_pin_out}, {8'h05, 64'h1});
    $display("write test done");
  endtask
  task automatic t_read();
    rd(1'h0, 7'h00, 8'h05, 1'h0);
    rd(1'h0, 7'h02, 8'h01, 1'h0);
    rd(1'h0, 7'h04, 8'h0f, 1'h0);
    rd(1'h0, 7'h09, 8'h00, 1'h0);
    rd(1'h0, 7'h01, 8'h00, 1'h1);
    rd(1'h0, 7'h0a, 8'h00, 1'h1);
    rd(1'h1, 7'h11, 8'h01, 1'h0);
    rd(1'h1, 7'h21, 8'h01, 1'h0);
    rd(1'h1, 7'h51, 8'h00, 1'h1);
    $display("read test done");
  endtask
  task automatic t_save();
    nv(1'h0);
    dir(8'h00);
    grp(9'h100, 4'h0, 64'h0);
    nv(1'h1);
    chk({io_direction_mask_out, main_pin_out, ext_pin_out}, {8'h41, 8'h05, 64'h1});
    $display("save test done");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'h1;
    @(posedge clk_sys_in) #1;
    t_dir();
    t_write();
    t_read();
    t_save();
    close_out();
  end
  initial begin
    #5000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
